// ---- logic/dtc_top.v ----
// Debug trace control: control and trigger registers, loop capture, break requests.
//
// Local design decision: the strobed register port.
`timescale 1ns/10ps
`include "dtc_defs.vh"
module dtc_top #(
  parameter AW = 17
) (
  input wire mclk, // core clock, 100 MHz
  input wire arst_n, // power-on reset, active low
  input wire [15:0] reg_addr, // register address
  input wire [7:0] reg_wdata, // register write data
  input wire reg_wr, // write strobe
  input wire reg_rd, // read strobe
  output reg [7:0] reg_rdata, // read data, cycle after strobe
  input wire secure_pin, // device secured, asynchronous level
  input wire end_run_rst, // end-run reset pulse
  input wire end_trace_rst, // end-trace reset pulse
  input wire cof_valid, // change of flow qualifies for storage
  input wire [AW-1:0] cof_addr, // change of flow address
  input wire cof_paged, // paged access indicator
  input wire trigger_hit, // decoded trigger from comparators
  input wire cmpc_match, // comparator C match
  input wire fifo_full, // trace FIFO full
  output reg fifo_wr, // trace FIFO write
  output reg [AW-1:0] fifo_addr, // FIFO entry address
  output reg fifo_paged, // FIFO entry paged indicator
  output wire [AW-1:0] cmpc_addr, // comparator C address
  output wire cmpc_paged, // comparator C paged indicator
  output wire module_en, // debug module enabled
  output wire armed, // comparisons and capture active
  output reg brk_force, // force breakpoint request
  output reg brk_tag, // tag breakpoint request
  output wire irq // interrupt, level
);
  ////////////////////////////////////////////////////////////////////
  reg [7:0] ctrl_q;
  reg [7:0] ctrl_d;
  reg [7:0] trig_q;
  reg [7:0] trig_d;
  reg [3:0] ists_q;
  reg [3:0] ists_d;
  reg [3:0] imask_q;
  reg started_q;
  reg started_d;
  wire secured;
  wire store;
  wire skip;
  wire loop_active;
  wire event_only;
  wire run_end;
  wire cap_en;
  wire [3:0] ev;

  dtc_sync2 u_sec (
    .mclk(mclk),
    .arst_n(arst_n),
    .din(secure_pin),
    .dout_q(secured)
  );

  function wr_hit;
    input [15:0] a;
    input [15:0] r;
    begin
      wr_hit = reg_wr && (a == r);
    end
  endfunction

  assign module_en = ctrl_q[`DTC_BIT_ENABLE]; // R01
  assign armed = ctrl_q[`DTC_BIT_ARM] && module_en; // R03
  assign event_only = (trig_q[3:0] == `DTC_TRG_EVB) || (trig_q[3:0] == `DTC_TRG_AEVB);
  assign loop_active = ctrl_q[`DTC_BIT_LOOP] && !event_only; // R12
  // Begin mode stores after the trigger; end mode stores until the trigger.
  assign cap_en = armed && (trig_q[`DTC_BIT_BEGIN] ? started_q : !started_q); // R16
  // A run ends at the trigger in end mode, or when the FIFO fills in begin mode.
  assign run_end = armed && (trig_q[`DTC_BIT_BEGIN] ? (started_q && fifo_full) : trigger_hit);

  dtc_loop_filter #(
    .AW(AW)
  ) u_loop (
    .mclk(mclk),
    .arst_n(arst_n),
    .cof_valid(cof_valid && cap_en && !fifo_full), // R03
    .cof_addr(cof_addr),
    .cof_paged(cof_paged),
    .loop_active(loop_active),
    .cmpc_load(1'b0),
    .cmpc_wdata({AW{1'b0}}),
    .cmpc_addr_q(cmpc_addr),
    .cmpc_paged_q(cmpc_paged),
    .store(store),
    .skip(skip)
  );

  ////////////////////////////////////////////////////////////////////
  always @* begin
    ctrl_d = ctrl_q;
    trig_d = trig_q;
    started_d = started_q;
    if (armed && trigger_hit && trig_q[`DTC_BIT_BEGIN])
      started_d = 1'b1; // R16
    if (wr_hit(reg_addr, `DTC_ADDR_CONTROL)) begin
      ctrl_d = reg_wdata & `DTC_CONTROL_WMASK; // R08 R17
      if (!ctrl_q[`DTC_BIT_ARM] && reg_wdata[`DTC_BIT_ARM])
        started_d = 1'b0;
    end
    if (wr_hit(reg_addr, `DTC_ADDR_TRIGGER) && !ctrl_q[`DTC_BIT_ARM])
      trig_d = reg_wdata & `DTC_TRIGGER_WMASK; // R15
    if (run_end)
      ctrl_d[`DTC_BIT_ARM] = 1'b0;
    // Trace-end reset with enable set and begin clear keeps the setup so the captured run can be read back.
    if (end_trace_rst && ctrl_q[`DTC_BIT_ENABLE] && !trig_q[`DTC_BIT_BEGIN]) begin
      ctrl_d[`DTC_BIT_ARM] = 1'b0; // R14
      ctrl_d[`DTC_BIT_CPU_BREAK_REQUEST_ENABLE] = 1'b0; // R14
    end else if (end_trace_rst) begin
      ctrl_d = `DTC_CONTROL_RESET;
      trig_d = `DTC_TRIGGER_RESET;
    end
    // End-run reset only drops arm; trigger bits stay as they are.
    if (end_run_rst)
      ctrl_d[`DTC_BIT_ARM] = 1'b0; // R13
    if (secured)
      ctrl_d[`DTC_BIT_ENABLE] = 1'b0; // R02
  end

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_q <= `DTC_CONTROL_RESET; // R13
      trig_q <= `DTC_TRIGGER_RESET; // R13
      started_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      trig_q <= trig_d;
      started_q <= started_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      fifo_wr <= 1'b0;
      fifo_addr <= {AW{1'b0}};
      fifo_paged <= 1'b0;
      brk_force <= 1'b0;
      brk_tag <= 1'b0;
    end else begin
      fifo_wr <= store; // R09 R10
      if (store) begin
        fifo_addr <= cof_addr; // R11
        fifo_paged <= cof_paged; // R11
      end
      // Break requests only go out with break enable set; kind unused otherwise.
      brk_force <= ctrl_q[`DTC_BIT_CPU_BREAK_REQUEST_ENABLE] && module_en && (run_end || cmpc_match)
        && !ctrl_q[`DTC_BIT_TAG]; // R04 R05 R06 R07
      brk_tag <= ctrl_q[`DTC_BIT_CPU_BREAK_REQUEST_ENABLE] && module_en && (run_end || cmpc_match)
        && ctrl_q[`DTC_BIT_TAG]; // R04 R05 R06 R07
    end
  end

  ////////////////////////////////////////////////////////////////////
  assign ev[`DTC_IRQ_STORE] = store;
  assign ev[`DTC_IRQ_SKIP] = skip;
  assign ev[`DTC_IRQ_BREAK] = ctrl_q[`DTC_BIT_CPU_BREAK_REQUEST_ENABLE] && module_en && (run_end || cmpc_match);
  assign ev[`DTC_IRQ_END] = run_end;
  assign irq = |(ists_q & imask_q);

  always @* begin
    ists_d = ists_q;
    if (reg_rd && reg_addr == `DTC_ADDR_IRQ_STATUS)
      ists_d = 4'h0;
    // A new event in the clearing cycle survives the read.
    ists_d = ists_d | ev;
  end

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ists_q <= 4'h0;
      imask_q <= 4'h0;
      reg_rdata <= 8'h00;
    end else begin
      ists_q <= ists_d;
      if (wr_hit(reg_addr, `DTC_ADDR_IRQ_MASK))
        imask_q <= reg_wdata[3:0];
      reg_rdata <= 8'h00;
      if (reg_rd) begin
        case (reg_addr)
          `DTC_ADDR_CONTROL: reg_rdata <= ctrl_q; // R08
          `DTC_ADDR_TRIGGER: reg_rdata <= trig_q;
          `DTC_ADDR_IRQ_STATUS: reg_rdata <= {4'h0, ists_q};
          `DTC_ADDR_IRQ_MASK: reg_rdata <= {4'h0, imask_q};
          default: reg_rdata <= 8'h00;
        endcase
      end
    end
  end
endmodule

// ---- logic/dtc_defs.vh ----
// Constants of the debug trace control block.
// Operation
// R01: Module enable bit 7 turns the debug module on; zero keeps it off.
// R02: While secured, module enable is held zero; writes setting it are ignored.
// R03: Comparisons and FIFO storage happen only while armed bit 6 is one.
// R04: Bit 5 picks the breakpoint kind: zero force, one tag request.
// R05: Breakpoint kind is ignored while break request enable is zero.
// R06: End of trace run requests a CPU breakpoint only if bit 4 set.
// R07: Comparator C raises a CPU breakpoint only while break enable is set.
// R08: Control bits 3 to 1 are read-only and read as zero.
// R09: With loop select zero, every qualifying change of flow is stored.
// R10: In loop mode, an address equal to comparator C is not stored.
// R11: In loop mode, a differing address is stored and loaded into comparator C.
// R12: Loop select is disregarded in event-only trigger modes.
// R13: End-run reset leaves trigger bits as they were; other resets restore defaults.
// R14: End-trace reset with enable set and begin clear clears arm and break only.
// R15: Trigger register writes are blocked unless the armed bit is zero.
// R16: Begin setting decides whether a trigger starts or ends FIFO storage.
// R17: Writes to reserved control bits are discarded; they read zero.
`ifndef DTC_DEFS_VH
`define DTC_DEFS_VH
`define DTC_ADDR_CONTROL 16'h301c
`define DTC_ADDR_TRIGGER 16'h301d
`define DTC_ADDR_IRQ_STATUS 16'h3020
`define DTC_ADDR_IRQ_MASK 16'h3021
`define DTC_BIT_ENABLE 7
`define DTC_BIT_ARM 6
`define DTC_BIT_TAG 5
`define DTC_BIT_CPU_BREAK_REQUEST_ENABLE 4
`define DTC_BIT_LOOP 0
`define DTC_CONTROL_RESET 8'hc0
`define DTC_CONTROL_WMASK 8'hf1
`define DTC_TRIGGER_RESET 8'h00
`define DTC_TRIGGER_WMASK 8'hcf
`define DTC_BIT_TRGSEL 7
`define DTC_BIT_BEGIN 6
`define DTC_TRG_EVB 4'h3
`define DTC_TRG_AEVB 4'h4
`define DTC_IRQ_STORE 0
`define DTC_IRQ_SKIP 1
`define DTC_IRQ_BREAK 2
`define DTC_IRQ_END 3
`endif

// ---- logic/dtc_loop_filter.v ----
// Single-loop filter: compares a change-of-flow entry with comparator C.
`timescale 1ns/10ps
module dtc_loop_filter #(
  parameter AW = 17
) (
  input wire mclk, // core clock
  input wire arst_n, // asynchronous reset, active low
  input wire cof_valid, // change of flow due for storage
  input wire [AW-1:0] cof_addr, // change of flow address
  input wire cof_paged, // paged access indicator of the entry
  input wire loop_active, // loop capture in force
  input wire cmpc_load, // software load of comparator C
  input wire [AW-1:0] cmpc_wdata, // address for software load
  output reg [AW-1:0] cmpc_addr_q, // comparator C address
  output reg cmpc_paged_q, // comparator C paged indicator
  output wire store, // entry goes into the FIFO
  output wire skip // entry suppressed as a repeat
);
  wire same;
  assign same = (cof_addr == cmpc_addr_q) && (cof_paged == cmpc_paged_q);
  assign skip = cof_valid && loop_active && same; // R10
  assign store = cof_valid && !skip; // R09
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cmpc_addr_q <= {AW{1'b0}};
      cmpc_paged_q <= 1'b0;
    end else if (cof_valid && loop_active && !same) begin
      cmpc_addr_q <= cof_addr; // R11
      cmpc_paged_q <= cof_paged; // R11
    end else if (cmpc_load) begin
      cmpc_addr_q <= cmpc_wdata;
      cmpc_paged_q <= 1'b0;
    end
  end
endmodule

// ---- logic/dtc_sync2.v ----
// Two-flip-flop synchroniser for a level.
`timescale 1ns/10ps
module dtc_sync2 (
  input wire mclk, // core clock
  input wire arst_n, // asynchronous reset, active low
  input wire din, // asynchronous level
  output reg dout_q // synchronised level
);
  reg meta_q;
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= 1'b0;
      dout_q <= 1'b0;
    end else begin
      meta_q <= din;
      dout_q <= meta_q;
    end
  end
endmodule

// ---- tb/dtc_top_asserts.sv ----
// Port-level assertions for the debug trace control block.
`timescale 1ns/10ps
module dtc_top_asserts #(
  parameter AW = 17
) (
  input wire mclk, // core clock
  input wire arst_n, // reset, active low
  input wire [15:0] reg_addr, // register address
  input wire reg_wr, // write strobe
  input wire reg_rd, // read strobe
  input wire [7:0] reg_rdata, // read data
  input wire secure_pin, // secured level
  input wire end_run_rst, // end-run reset pulse
  input wire cof_valid, // entry offered
  input wire [AW-1:0] cof_addr, // entry address
  input wire cof_paged, // entry paged flag
  input wire fifo_wr, // FIFO write
  input wire [AW-1:0] fifo_addr, // FIFO entry address
  input wire fifo_paged, // FIFO entry paged flag
  input wire module_en, // module enabled
  input wire armed, // capture armed
  input wire brk_force, // force request
  input wire brk_tag // tag request
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  chk_reserved_zero: assert property (
    $past(reg_rd) && $past(reg_addr) == 16'h301c |-> reg_rdata[3:1] == 3'b000)
    else $error("reserved control bits read nonzero");
  chk_ctrl_readback: assert property (
    $past(reg_rd) && $past(reg_addr) == 16'h301c |->
      reg_rdata[7] == $past(module_en) && (reg_rdata[7] && reg_rdata[6]) == $past(armed))
    else $error("control read disagrees with enable or arm");
  chk_store_armed: assert property (
    fifo_wr |-> $past(armed && cof_valid))
    else $error("FIFO written without armed entry");
  chk_store_entry: assert property (
    fifo_wr |-> fifo_addr == $past(cof_addr) && fifo_paged == $past(cof_paged))
    else $error("FIFO entry differs from offered entry");
  chk_kind_single: assert property (
    !(brk_force && brk_tag))
    else $error("force and tag requested together");
  chk_break_enabled: assert property (
    brk_force || brk_tag |-> $past(module_en))
    else $error("break requested while module off");
  chk_secure_off: assert property (
    secure_pin [*3] |=> !module_en)
    else $error("module enabled while secured");
  chk_run_disarm: assert property (
    end_run_rst && !reg_wr |=> !armed)
    else $error("still armed after end-run reset");
endmodule
bind dtc_top dtc_top_asserts #(.AW(AW)) u_dtc_top_asserts (.mclk(mclk), .arst_n(arst_n),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .secure_pin(secure_pin), .end_run_rst(end_run_rst), .cof_valid(cof_valid),
  .cof_addr(cof_addr), .cof_paged(cof_paged), .fifo_wr(fifo_wr), .fifo_addr(fifo_addr),
  .fifo_paged(fifo_paged), .module_en(module_en), .armed(armed), .brk_force(brk_force),
  .brk_tag(brk_tag));

// ---- tb/dtc_cpu_model.sv ----
// CPU-side model that counts the breakpoint requests it receives.
`timescale 1ns/10ps
module dtc_cpu_model (
  input wire mclk, // core clock
  input wire brk_force, // force request
  input wire brk_tag // tag request
);
  integer n_force = 0;
  integer n_tag = 0;
  always @(posedge mclk) begin
    if (brk_force) n_force <= n_force + 1;
    if (brk_tag) n_tag <= n_tag + 1;
  end
endmodule

// ---- tb/test_dtc_top.sv ----
// Self-checking testbench for the debug trace control block.
`timescale 1ns/10ps
module test_dtc_top;
  reg mclk = 1'b0;
  reg arst_n = 1'b0;
  reg [15:0] reg_addr = 16'h0000;
  reg [7:0] reg_wdata = 8'h00;
  reg reg_wr = 1'b0, reg_rd = 1'b0, secure_pin = 1'b0;
  reg end_run_rst = 1'b0, end_trace_rst = 1'b0, cof_valid = 1'b0, cof_paged = 1'b0;
  reg trigger_hit = 1'b0, cmpc_match = 1'b0, fifo_full = 1'b0;
  reg [16:0] cof_addr = 17'h00000;
  wire [7:0] reg_rdata;
  wire [16:0] cmpc_addr, fifo_addr;
  wire fifo_wr, fifo_paged, cmpc_paged, brk_force, brk_tag, irq;
  integer n_errors = 0;
  integer comparisons = 0;
  dtc_top u_dtc_top (.mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .secure_pin(secure_pin),
    .end_run_rst(end_run_rst), .end_trace_rst(end_trace_rst), .cof_valid(cof_valid),
    .cof_addr(cof_addr), .cof_paged(cof_paged), .trigger_hit(trigger_hit),
    .cmpc_match(cmpc_match), .fifo_full(fifo_full), .fifo_wr(fifo_wr), .fifo_addr(fifo_addr),
    .fifo_paged(fifo_paged), .cmpc_addr(cmpc_addr), .cmpc_paged(cmpc_paged), .module_en(),
    .armed(),
    .brk_force(brk_force), .brk_tag(brk_tag), .irq(irq));
  dtc_cpu_model u_dtc_cpu_model (.mclk(mclk), .brk_force(brk_force), .brk_tag(brk_tag));
  initial begin
    forever #5 mclk = ~mclk;
  end
  task ck(input [16:0] g, input [16:0] e);
    comparisons = comparisons + 1;
    if (g !== e) begin
      n_errors = n_errors + 1;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task wr(input [15:0] a, input [7:0] d);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge mclk); reg_wr <= 1'b0; @(posedge mclk);
  endtask
  task rd(input [15:0] a, input [7:0] e);
    reg_addr <= a; reg_rd <= 1'b1;
    @(posedge mclk); reg_rd <= 1'b0;
    #1 ck(reg_rdata, e);
    @(posedge mclk);
  endtask
  task change_of_flow(input [16:0] a, input p, input w);
    cof_valid <= 1'b1; cof_addr <= a; cof_paged <= p;
    @(posedge mclk); cof_valid <= 1'b0;
    #1 ck(fifo_wr, w);
    @(posedge mclk);
  endtask
  // Pulse kinds: 0 trigger, 1 comparator C, 2 end-trace reset, 3 end-run reset.
  task pl(input integer k);
    trigger_hit <= (k == 0); cmpc_match <= (k == 1);
    end_trace_rst <= (k == 2); end_run_rst <= (k == 3);
    @(posedge mclk);
    trigger_hit <= 1'b0; cmpc_match <= 1'b0; end_trace_rst <= 1'b0; end_run_rst <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask
  task t_regs;
    rd(16'h301c, 8'hc0);
    rd(16'h3030, 8'h00);
    wr(16'h301d, 8'h41); rd(16'h301d, 8'h00);
    wr(16'h301c, 8'h8e); rd(16'h301c, 8'h80);
    wr(16'h301d, 8'hff); rd(16'h301d, 8'hcf);
    wr(16'h301d, 8'h00);
    $display("t_regs done");
  endtask
  task t_loop;
    wr(16'h301c, 8'hc1);
    change_of_flow(17'h1abcd, 1'b1, 1'b1); ck(cmpc_addr, 17'h1abcd); ck(cmpc_paged, 1'b1);
    change_of_flow(17'h1abcd, 1'b1, 1'b0);
    change_of_flow(17'h00123, 1'b0, 1'b1);
    wr(16'h301c, 8'hc0); change_of_flow(17'h00123, 1'b0, 1'b1);
    wr(16'h301c, 8'h80); wr(16'h301d, 8'h03); wr(16'h301c, 8'hc1);
    change_of_flow(17'h00123, 1'b0, 1'b1); change_of_flow(17'h00123, 1'b0, 1'b1);
    $display("t_loop done");
  endtask
  task t_break;
    wr(16'h301c, 8'h80); wr(16'h301d, 8'h00); rd(16'h3020, 8'h03);
    wr(16'h3021, 8'h0f); wr(16'h301c, 8'hd0); pl(0);
    ck(u_dtc_cpu_model.n_force, 1); ck(irq, 1);
    rd(16'h3020, 8'h0c); ck(irq, 0);
    wr(16'h301c, 8'hf0); pl(0); ck(u_dtc_cpu_model.n_tag, 1);
    wr(16'h301c, 8'he0); pl(1); ck(u_dtc_cpu_model.n_tag, 1);
    ck(u_dtc_cpu_model.n_force, 1);
    wr(16'h301c, 8'hd0); pl(1); ck(u_dtc_cpu_model.n_force, 2);
    wr(16'h3021, 8'h00); ck(irq, 0);
    $display("t_break done");
  endtask
  task t_resets;
    wr(16'h301c, 8'h80); wr(16'h301d, 8'h83); wr(16'h301c, 8'hf1); pl(2);
    rd(16'h301c, 8'ha1); rd(16'h301d, 8'h83);
    wr(16'h301d, 8'h40); wr(16'h301c, 8'hf1); pl(2);
    rd(16'h301c, 8'hc0); rd(16'h301d, 8'h00);
    pl(3); rd(16'h301c, 8'h80);
    $display("t_resets done");
  endtask
  // Begin mode: nothing stored before the trigger, a full FIFO ends the run.
  task t_begin;
    wr(16'h301d, 8'h40); wr(16'h301c, 8'hc0);
    change_of_flow(17'h00200, 1'b1, 1'b0);
    pl(0); change_of_flow(17'h00200, 1'b1, 1'b1);
    ck(fifo_addr, 17'h00200); ck(fifo_paged, 1'b1);
    fifo_full <= 1'b1; change_of_flow(17'h00300, 1'b0, 1'b0);
    fifo_full <= 1'b0; rd(16'h301c, 8'h80);
    wr(16'h301d, 8'h00);
    $display("t_begin done");
  endtask
  task t_secure;
    secure_pin <= 1'b1; repeat (4) @(posedge mclk);
    wr(16'h301c, 8'hc0); rd(16'h301c, 8'h40);
    secure_pin <= 1'b0; repeat (4) @(posedge mclk);
    $display("t_secure done");
  endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    #50000;
    n_errors = n_errors + 1;
    tally_and_finish;
  end
  initial begin
    repeat (20) @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    t_regs; t_loop; t_break; t_resets; t_begin; t_secure;
    tally_and_finish;
  end
endmodule
